// *** adcm_defs.svh ***
// timing counts and field positions for the bus-port converter control
`ifndef ADCM_DEFS_SVH
`define ADCM_DEFS_SVH
`define ADCM_CONV_TIME_US      40
`define ADCM_CLK_MHZ           200
`define ADCM_CONV_CYCLES       (`ADCM_CONV_TIME_US * `ADCM_CLK_MHZ)
`define ADCM_STEP_CYCLES       (`ADCM_CONV_CYCLES / 9)
`define ADCM_HALF_STEP         (`ADCM_STEP_CYCLES / 2)
`define ADCM_SEL_W             5
`define ADCM_DATA_W            8
`define ADCM_CODES             256
`define ADCM_SEL_BIT_SGL       3
`define ADCM_SEL_BIT_PSD       4
`define ADCM_SEL_BIT_PSD4      2
`define ADCM_SEL_RESET         5'h00
`define ADCM_FIFO_DEPTH        4
`endif

// *** adcm_pkg.sv ***
// types shared by the converter control modules
package adcm_pkg;
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_SAMPLE = 4'b0010,
    ST_SAR    = 4'b0100,
    ST_DONE   = 4'b1000
  } adcm_state_type;
  typedef enum logic [1:0] {
    MODE_DIFF   = 2'h0,
    MODE_SINGLE = 2'h1,
    MODE_PSEUDO = 2'h2
  } adcm_mode_type;
endpackage : adcm_pkg

// *** adcm_stream_if.sv ***
// valid/ready carrier between converter core and result buffer
`timescale 1ns/1ps
interface adcm_stream_if #(parameter int WIDTH = 8);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface : adcm_stream_if

// *** adcm_fifo.sv ***
// small result FIFO with valid/ready on both sides
`timescale 1ns/1ps
module adcm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic clk,       // system clock
  input  wire logic sys_rst,   // sync reset, high
  adcm_stream_if.sink   inPort,  // filling side
  adcm_stream_if.source outPort  // draining side
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr, rdPtr, next_wrPtr, next_rdPtr;
  logic [AW:0]      count, next_count;
  logic             doWr, doRd;

  // honest flags; ready drops when full so the core stalls
  assign inPort.ready  = (count != (AW+1)'(DEPTH));
  assign outPort.valid = (count != '0);
  assign outPort.data  = mem[rdPtr];
  assign doWr = inPort.valid & inPort.ready;
  assign doRd = outPort.valid & outPort.ready;

  // pointer and count next values
  always_comb begin
    next_wrPtr = doWr ? AW'(wrPtr + 1'b1) : wrPtr;
    next_rdPtr = doRd ? AW'(rdPtr + 1'b1) : rdPtr;
    next_count = count;
    if (doWr && !doRd) begin
      next_count = count + 1'b1;
    end else if (doRd && !doWr) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk) begin
    if (doWr) begin
      mem[wrPtr] <= inPort.data;
    end
  end
endmodule : adcm_fifo

// *** adcm_bus_port.sv ***
// bus-port control of an 8-bit successive-approximation converter
`timescale 1ns/1ps
`include "adcm_defs.svh"
// Function
// - write strobe falling edge raises done flag and readies a conversion.
// - write rising edge with read high latches select bits, starts conversion.
// - select bits come from low five bus lines, only while read high.
// - read low across whole write pulse keeps config, drives old result.
// - conversion end latches result and drives done flag low.
// - chip select and read low raise done flag and present result.
// - done flag stays low until result read or new write.
// - result is positive minus negative input, zero when negative.
// - four-input differential pairs 1-2, 3-4, low bit sets polarity.
// - four-input single-ended uses chosen input against analog ground.
// - four-input pseudo-differential uses inputs 1-3 against input 4.
// - eight-input variant decodes the same three modes over eight inputs.
// - 256 codes span the reference; one step is reference over 256.
// - positive input sampled, negative half an internal period later.
// - comparator decided at end of each internal clock period.
// - chip-select read also starts a conversion on unchanged config.
module adcm_bus_port #(
  parameter int EIGHT_INPUTS = 1,
  parameter int CONV_CYCLES  = `ADCM_CONV_CYCLES
) (
  input  wire logic        clk,            // 200 MHz system clock
  input  wire logic        sys_rst,        // sync reset, high
  input  wire logic        chipSelect_n,   // chip select pin, low
  input  wire logic        writeStrobe_n,  // write strobe pin, low
  input  wire logic        readStrobe_n,   // read strobe pin, low
  input  wire logic [7:0]  dataBusIn,      // data bus lines, input side
  output logic      [7:0]  dataBusOut,     // data bus lines, driven value
  output logic             dataBusOe,      // high while driving the bus
  output logic             doneFlag_n,     // done flag, low when ready
  input  wire logic [7:0]  analogPos [8],  // digitised analog inputs
  input  wire logic [7:0]  analogRef,      // reference, full-scale value
  output logic      [4:0]  channelSelect,  // selector latch contents
  output logic      [7:0]  sampleCount,    // step counter, observable
  output logic             busy            // conversion in progress
);
  localparam int STEP = CONV_CYCLES / 9;
  localparam int HALF = STEP / 2;

  // two-flop synchronisers for the pins
  logic [2:0] pinMeta, pinSync, pinLast;
  logic [7:0] busMeta, busSync;
  always_ff @(posedge clk) begin
    pinMeta <= {chipSelect_n, writeStrobe_n, readStrobe_n};
    pinSync <= pinMeta;
    busMeta <= dataBusIn;
    busSync <= busMeta;
  end
  logic csN, wrN, rdN, wrLast, rdLast;
  assign {csN, wrN, rdN} = pinSync;
  assign {wrLast, rdLast} = pinLast[1:0];

  logic wrFall, wrRise, rdFall, rdLowAll, next_rdLowAll;
  assign wrFall = !csN && wrLast && !wrN;
  assign wrRise = !csN && !wrLast && wrN;
  assign rdFall = !csN && rdLast && !rdN;

  // track whether read stayed low for the whole write pulse
  always_comb begin
    next_rdLowAll = rdLowAll;
    if (wrFall) begin
      next_rdLowAll = !rdN;
    end else if (!wrN && rdN) begin
      next_rdLowAll = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pinLast  <= 3'h7;
      rdLowAll <= 1'b0;
    end else begin
      pinLast  <= {1'b1, wrN, rdN};
      rdLowAll <= next_rdLowAll;
    end
  end

  // selector latch
  logic [4:0] next_sel;
  logic       startConv;
  always_comb begin
    next_sel  = channelSelect;
    startConv = 1'b0;
    if (wrRise && !rdLowAll && rdN) begin
      next_sel  = busSync[4:0];
      startConv = 1'b1;
    end else if (wrRise && rdLowAll) begin
      startConv = 1'b1;
    end else if (rdFall) begin
      startConv = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      channelSelect <= `ADCM_SEL_RESET;
    end else begin
      channelSelect <= next_sel;
    end
  end

  // mode decode; pseudo-differential picks top bit on 8-input part
  adcm_pkg::adcm_mode_type mode;
  logic [2:0] posIdx, negIdx;
  logic       negGround, undefCode;
  always_comb begin
    negGround = 1'b0;
    undefCode = 1'b0;
    posIdx    = 3'h0;
    negIdx    = 3'h0;
    mode      = adcm_pkg::MODE_DIFF;
    if (EIGHT_INPUTS != 0) begin
      if (!channelSelect[3]) begin
        mode   = adcm_pkg::MODE_DIFF;
        posIdx = {channelSelect[2:1], channelSelect[0]};
        negIdx = {channelSelect[2:1], !channelSelect[0]};
      end else if (!channelSelect[4]) begin
        mode      = adcm_pkg::MODE_SINGLE;
        posIdx    = channelSelect[2:0];
        negGround = 1'b1;
      end else begin
        mode      = adcm_pkg::MODE_PSEUDO;
        posIdx    = channelSelect[2:0];
        negIdx    = 3'h7;
        undefCode = (channelSelect[2:0] == 3'h7);
      end
    end else begin
      if (!channelSelect[2]) begin
        mode   = adcm_pkg::MODE_DIFF;
        posIdx = {1'b0, channelSelect[1], channelSelect[0]};
        negIdx = {1'b0, channelSelect[1], !channelSelect[0]};
      end else if (!channelSelect[3]) begin
        mode      = adcm_pkg::MODE_SINGLE;
        posIdx    = {1'b0, channelSelect[1:0]};
        negGround = 1'b1;
      end else begin
        mode      = adcm_pkg::MODE_PSEUDO;
        posIdx    = {1'b0, channelSelect[1:0]};
        negIdx    = 3'h3;
        undefCode = (channelSelect[1:0] == 2'h3);
      end
    end
  end

  // conversion engine: sample, eight comparator steps
  adcm_pkg::adcm_state_type state, next_state;
  logic [13:0] tick, next_tick;
  logic [7:0]  posVal, negVal, next_posVal, next_negVal;
  logic [7:0]  trial, next_trial;
  logic [3:0]  bitIdx, next_bitIdx;
  logic [8:0]  diff;
  logic [15:0] scaled;
  logic [7:0]  target;
  logic        pending, next_pending;
  adcm_stream_if #(.WIDTH(8)) toFifo ();
  adcm_stream_if #(.WIDTH(8)) fromFifo ();

  // result code is the difference scaled to the reference span
  always_comb begin
    diff   = {1'b0, posVal} - {1'b0, negVal};
    scaled = diff[8] ? 16'h0000
           : (analogRef == 8'h00) ? 16'h00ff
           : 16'((diff[7:0] * 16'h0100) / {8'h00, analogRef});
    target = (scaled > 16'h00ff) ? 8'hff : scaled[7:0];
  end

  always_comb begin
    next_state   = state;
    next_tick    = tick;
    next_posVal  = posVal;
    next_negVal  = negVal;
    next_trial   = trial;
    next_bitIdx  = bitIdx;
    next_pending = pending;
    toFifo.valid = 1'b0;
    toFifo.data  = trial;
    if (startConv) begin
      next_state  = adcm_pkg::ST_SAMPLE;
      next_tick   = '0;
      next_trial  = 8'h80;
      next_bitIdx = 4'h7;
    end else begin
      case (state)
        adcm_pkg::ST_IDLE: begin
          next_tick = '0;
        end
        adcm_pkg::ST_SAMPLE: begin
          next_tick = 14'(tick + 1'b1);
          if (tick == 14'h0000) begin
            next_posVal = analogPos[posIdx];
          end
          if (tick == 14'(HALF)) begin
            next_negVal = negGround ? 8'h00 : analogPos[negIdx];
          end
          if (tick == 14'(STEP - 1)) begin
            next_tick  = '0;
            next_state = adcm_pkg::ST_SAR;
          end
        end
        adcm_pkg::ST_SAR: begin
          next_tick = 14'(tick + 1'b1);
          if (tick == 14'(STEP - 1)) begin
            next_tick = '0;
            if (trial > target) begin
              next_trial[bitIdx[2:0]] = 1'b0;
            end
            if (bitIdx == 4'h0) begin
              next_state = adcm_pkg::ST_DONE;
            end else begin
              next_trial[bitIdx[2:0] - 3'h1] = 1'b1;
              next_bitIdx = bitIdx - 4'h1;
            end
          end
        end
        adcm_pkg::ST_DONE: begin
          toFifo.valid = 1'b1;                  // waits while buffer full
          if (undefCode) begin
            toFifo.data = 8'h00;
          end
          if (toFifo.ready) begin
            next_state   = adcm_pkg::ST_IDLE;
            next_pending = 1'b1;
          end
        end
        default: next_state = adcm_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state   <= adcm_pkg::ST_IDLE;
      tick    <= '0;
      posVal  <= 8'h00;
      negVal  <= 8'h00;
      trial   <= 8'h80;
      bitIdx  <= 4'h7;
      pending <= 1'b0;
    end else begin
      state   <= next_state;
      tick    <= next_tick;
      posVal  <= next_posVal;
      negVal  <= next_negVal;
      trial   <= next_trial;
      bitIdx  <= next_bitIdx;
      pending <= next_pending;
    end
  end

  adcm_fifo #(
    .WIDTH (8),
    .DEPTH (`ADCM_FIFO_DEPTH)
  ) u_fifo (
    .clk     (clk),
    .sys_rst (sys_rst),
    .inPort  (toFifo),
    .outPort (fromFifo)
  );

  // output latch and done flag; newest result always wins
  logic [7:0] outLatch, next_outLatch;
  logic       next_done_n;
  assign fromFifo.ready = 1'b1;
  always_comb begin
    next_outLatch = outLatch;
    next_done_n   = doneFlag_n;
    if (fromFifo.valid) begin
      next_outLatch = fromFifo.data;
    end
    if (wrFall || rdFall) begin
      next_done_n = 1'b1;
    end
    if (fromFifo.valid) begin
      next_done_n = 1'b0;                      // set wins
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      outLatch   <= 8'h00;
      doneFlag_n <= 1'b1;
    end else begin
      outLatch   <= next_outLatch;
      doneFlag_n <= next_done_n;
    end
  end

  // bus drive only while selected and read low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dataBusOut <= 8'h00;
      dataBusOe  <= 1'b0;
    end else begin
      dataBusOut <= outLatch;
      dataBusOe  <= !csN && !rdN;
    end
  end

  assign busy        = (state != adcm_pkg::ST_IDLE);
  assign sampleCount = {4'h0, bitIdx};
endmodule : adcm_bus_port

// *** adcm_bus_port_sva.sv ***
// pin-level checks for the converter bus-port control
`timescale 1ns/1ps
module adcm_bus_port_chk (
  input wire logic       clk,           // system clock
  input wire logic       sys_rst,       // sync reset, high
  input wire logic       chipSelect_n,  // chip select pin
  input wire logic       writeStrobe_n, // write strobe pin
  input wire logic       readStrobe_n,  // read strobe pin
  input wire logic [7:0] dataBusIn,     // bus level seen
  input wire logic [7:0] dataBusOut,    // driven result
  input wire logic       dataBusOe,     // bus enable
  input wire logic       doneFlag_n,    // done flag
  input wire logic [4:0] channelSelect, // selector latch
  input wire logic       busy           // converting
);
  logic [4:0] selBits;
  // low bus lines only; upper bits must never reach the latch
  assign selBits = dataBusIn[4:0];
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_bus_off;
    (chipSelect_n || readStrobe_n) [*5] |-> !dataBusOe;
  endproperty
  a_bus_off: assert property (p_bus_off) else $error("stray drive");
  property p_bus_on;
    (!chipSelect_n && !readStrobe_n) [*5] |-> dataBusOe && doneFlag_n;
  endproperty
  a_bus_on: assert property (p_bus_on) else $error("read ignored");
  property p_wr_clear;
    (!chipSelect_n && !writeStrobe_n) [*5] |-> doneFlag_n;
  endproperty
  a_wr_clear: assert property (p_wr_clear) else $error("done kept");
  property p_done_hold;
    (readStrobe_n && writeStrobe_n) [*4] ##0 !doneFlag_n |=> !doneFlag_n;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("done lost");
  property p_sel_latch;
    $rose(writeStrobe_n) && !chipSelect_n && readStrobe_n
      |-> ##5 channelSelect == $past(selBits, 5);
  endproperty
  a_sel_latch: assert property (p_sel_latch) else $error("bad latch");
  property p_sel_keep;
    (!readStrobe_n) [*5] |=> $stable(channelSelect);
  endproperty
  a_sel_keep: assert property (p_sel_keep) else $error("sel moved");
  property p_out_steady;
    dataBusOe && $past(dataBusOe) |-> $stable(dataBusOut);
  endproperty
  a_out_steady: assert property (p_out_steady) else $error("bus moved");
  property p_done_end;
    $fell(busy) |-> ##[0:4] !doneFlag_n;
  endproperty
  a_done_end: assert property (p_done_end) else $error("no done");
endmodule : adcm_bus_port_chk

bind adcm_bus_port adcm_bus_port_chk u_chk (
  .clk(clk), .sys_rst(sys_rst), .chipSelect_n(chipSelect_n),
  .writeStrobe_n(writeStrobe_n), .readStrobe_n(readStrobe_n),
  .dataBusIn(dataBusIn), .dataBusOut(dataBusOut), .dataBusOe(dataBusOe),
  .doneFlag_n(doneFlag_n), .channelSelect(channelSelect), .busy(busy)
);

// *** adcm_cpu_model.sv ***
// processor model driving the converter control pins
`timescale 1ns/1ps
module adcm_cpu_model (
  input  wire logic       clk,           // system clock
  input  wire logic [7:0] busLevel,      // resolved bus lines
  input  wire logic       doneFlag_n,    // done flag
  output logic            chipSelect_n,  // chip select
  output logic            writeStrobe_n, // write strobe
  output logic            readStrobe_n,  // read strobe
  output logic      [7:0] dataDrive      // processor bus value
);
  // idle pins at time zero
  initial begin
    chipSelect_n  = 1'b1;
    writeStrobe_n = 1'b1;
    readStrobe_n  = 1'b1;
    dataDrive     = 8'h00;
  end
  // one bus cycle; released data inverts so stale values show
  task automatic bus_cycle(input logic csOn, wrOn, rdOn,
                           input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    chipSelect_n <= !csOn;
    readStrobe_n <= !rdOn;
    dataDrive    <= d;
    repeat (2) @(posedge clk);
    if (wrOn) begin
      writeStrobe_n <= 1'b0;
      repeat (30) @(posedge clk);
      writeStrobe_n <= 1'b1;
    end
    repeat (6) @(posedge clk);
    q = busLevel;
    chipSelect_n <= 1'b1;
    readStrobe_n <= 1'b1;
    dataDrive    <= ~d;
  endtask : bus_cycle
  // poll done, then keep the gap the flag needs before a read
  task automatic wait_done(output int n);
    n = 0;
    while (doneFlag_n !== 1'b0 && n < 200) begin
      @(posedge clk);
      n++;
    end
    repeat (120) @(posedge clk);
  endtask : wait_done
endmodule : adcm_cpu_model

// *** adcm_bus_port_test.sv ***
// self-checking bench for the converter bus-port control
`timescale 1ns/1ps
module adcm_bus_port_test;
  localparam int CONV = 90;
  logic       clk;
  logic       sysRst;
  logic       chipSelect_n;
  logic       writeStrobe_n;
  logic       readStrobe_n;
  logic [7:0] cpuData;
  logic [7:0] busLevel;
  logic [7:0] dataBusOut;
  logic       dataBusOe;
  logic       doneFlag_n;
  logic [7:0] analogPos [8];
  logic [7:0] analogRef;
  logic [4:0] channelSelect;
  logic [7:0] sampleCount;
  logic       busy;
  int         error_cnt = 0;
  int         num_checks = 0;
  // no pull on the bus: whoever enables wins
  assign busLevel = dataBusOe ? dataBusOut : cpuData;
  adcm_bus_port #(.EIGHT_INPUTS(1), .CONV_CYCLES(CONV)) u_dut (
    .clk(clk), .sys_rst(sysRst), .chipSelect_n(chipSelect_n),
    .writeStrobe_n(writeStrobe_n), .readStrobe_n(readStrobe_n),
    .dataBusIn(busLevel), .dataBusOut(dataBusOut), .dataBusOe(dataBusOe),
    .doneFlag_n(doneFlag_n), .analogPos(analogPos), .analogRef(analogRef),
    .channelSelect(channelSelect), .sampleCount(sampleCount),
    .busy(busy));
  adcm_cpu_model u_cpu (
    .clk(clk), .busLevel(busLevel), .doneFlag_n(doneFlag_n),
    .chipSelect_n(chipSelect_n), .writeStrobe_n(writeStrobe_n),
    .readStrobe_n(readStrobe_n), .dataDrive(cpuData));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // expected code: positive minus negative input, scaled by the span
  function automatic logic [7:0] code_of(input logic [4:0] s);
    int p, n, d;
    p = analogPos[s[2:0]];
    n = !s[3] ? analogPos[s[2:0] ^ 3'h1] : s[4] ? analogPos[7] : 0;
    d = (p > n) ? (p - n) * 256 / analogRef : 0;
    return (d > 255) ? 8'hff : 8'(d);
  endfunction : code_of
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out
  task automatic t_reset;
    chk({dataBusOe, doneFlag_n, busy, channelSelect}, 8'h40);
  endtask : t_reset
  // write a select, wait, read back; next write follows the read at once
  task automatic convert(input logic [4:0] s);
    logic [7:0] q;
    int n;
    u_cpu.bus_cycle(1'b1, 1'b1, 1'b0, {3'b111, s}, q);
    chk(8'(channelSelect), 8'(s));
    chk(8'(doneFlag_n), 8'h01);
    u_cpu.wait_done(n);
    chk(8'(n > CONV - 20 && n < CONV + 20), 8'h01);
    chk(8'(doneFlag_n), 8'h00);
    chk(sampleCount, 8'h00);
    chk(8'(busy), 8'h00);
    u_cpu.bus_cycle(1'b1, 1'b0, 1'b1, 8'h00, q);
    chk(q, code_of(s));
    chk(8'(doneFlag_n), 8'h01);
  endtask : convert
  // every mode and polarity, the undefined code, and a clipped span
  task automatic t_modes;
    logic [4:0] sels [8];
    sels = '{5'h00, 5'h01, 5'h06, 5'h08, 5'h0f, 5'h18, 5'h1e, 5'h1f};
    foreach (sels[i]) convert(sels[i]);
    analogRef <= 8'h40;
    convert(5'h0e);
  endtask : t_modes
  // strobes with chip select high must leave pins and latch alone
  task automatic t_cs_high;
    logic [7:0] q;
    u_cpu.bus_cycle(1'b0, 1'b1, 1'b1, 8'h08, q);
    chk(q, 8'h08);
    chk(8'(channelSelect), 8'h0e);
  endtask : t_cs_high
  // read held across a write keeps the setup and shows the old result
  task automatic t_read_held;
    logic [7:0] q;
    int n;
    u_cpu.wait_done(n);
    chk(8'(n < CONV + 20), 8'h01);
    u_cpu.bus_cycle(1'b1, 1'b1, 1'b1, 8'h01, q);
    chk(q, code_of(5'h0e));
    chk(8'(channelSelect), 8'h0e);
    u_cpu.wait_done(n);
    u_cpu.bus_cycle(1'b1, 1'b0, 1'b1, 8'h00, q);
    chk(q, code_of(5'h0e));
  endtask : t_read_held
  // main sequence
  initial begin
    sysRst    = 1'b1;
    analogRef = 8'h80;
    analogPos = '{8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h60, 8'h70, 8'h08};
    repeat (12) @(posedge clk);
    sysRst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_modes();
    t_cs_high();
    t_read_held();
    close_out();
  end
  // watchdog well past the expected few thousand cycles
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    close_out();
  end
endmodule : adcm_bus_port_test
